// [inc/pin_select_pkg.sv]
// shared constants and carrier types for the peripheral pin select block
// assumes a single 100 MHz system clock and an APB register port
package pin_select_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_PINS   = 24;
    localparam int NUM_INSEL  = 43;
    localparam int SEL_W      = 6;
    localparam int APB_ADDR_W = 12;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_LOCK     = 12'h000;
    localparam logic [11:0] ADDR_IN_BASE  = 12'h100;
    localparam logic [11:0] ADDR_OUT_BASE = 12'h200;
    localparam int          LOCK_BIT      = 0;
    localparam int          SEL_LSB       = 0;
    localparam int          SEL_MSB       = 5;
    localparam logic        LOCK_RESET    = 1'b0;
    localparam logic [5:0]  OUT_SEL_RESET = 6'h00;

    // pin codes: first port 0..7, second port 8..15, third port 16..23
    localparam logic [1:0] PORT_FIRST  = 2'h0;
    localparam logic [1:0] PORT_SECOND = 2'h1;
    localparam logic [1:0] PORT_THIRD  = 2'h2;

    // input selector values after reset, in register table order
    localparam logic [5:0] IN_SEL_RESET [0:NUM_INSEL-1] = '{
        6'h08, 6'h04, 6'h10, 6'h0D, 6'h10, 6'h10, 6'h12, 6'h0C,
        6'h13, 6'h15, 6'h0F, 6'h14, 6'h12, 6'h11, 6'h0D, 6'h08,
        6'h09, 6'h0A, 6'h03, 6'h04, 6'h05, 6'h13, 6'h14, 6'h15,
        6'h0B, 6'h0C, 6'h0D, 6'h04, 6'h05, 6'h11, 6'h12, 6'h14,
        6'h15, 6'h0C, 6'h13, 6'h14, 6'h05, 6'h17, 6'h16, 6'h00,
        6'h01, 6'h0E, 6'h0F};

    // ------------------------------------------------------------
    // output source codes
    // ------------------------------------------------------------
    localparam logic [5:0] CODE_LATCH     = 6'h00;
    localparam logic [5:0] CODE_LC_FIRST  = 6'h01;
    localparam logic [5:0] CODE_LC_LAST   = 6'h04;
    localparam logic [5:0] CODE_COG_FIRST = 6'h05;
    localparam logic [5:0] CODE_COG_LAST  = 6'h10;
    localparam logic [5:0] CODE_CCP1      = 6'h15;
    localparam logic [5:0] CODE_CCP2      = 6'h16;
    localparam logic [5:0] CODE_CCP7      = 6'h17;
    localparam logic [5:0] CODE_PWM3      = 6'h19;
    localparam logic [5:0] CODE_PWM4      = 6'h1A;
    localparam logic [5:0] CODE_PWM9      = 6'h1B;
    localparam logic [5:0] CODE_PWM5      = 6'h1D;
    localparam logic [5:0] CODE_PWM6      = 6'h1E;
    localparam logic [5:0] CODE_PWM11     = 6'h1F;
    localparam logic [5:0] CODE_SER_FIRST = 6'h21;
    localparam logic [5:0] CODE_SER_LAST  = 6'h25;
    localparam logic [5:0] CODE_CMP_FIRST = 6'h26;
    localparam logic [5:0] CODE_CMP_LAST  = 6'h2B;
    localparam logic [5:0] CODE_MOD_FIRST = 6'h2E;
    localparam logic [5:0] CODE_MOD_LAST  = 6'h30;

    // which source codes each port may carry; third port takes either set
    localparam logic [63:0] SRC_ON_FIRST  = 64'h0000_CCC0_6E01_E007;
    localparam logic [63:0] SRC_ON_SECOND = 64'h0001_033E_80E0_1FF8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  modulatorOutput;
        logic [5:0]  syncedComparatorOutput;
        logic        syncUartDataOut;
        logic        uartTransmitOrClock;
        logic        spiDataOut;
        logic        serialData;
        logic        serialClock;
        logic [5:0]  pulseWidthOutput;      // units 3,4,9,5,6,11
        logic [2:0]  captureCompareOutput;  // units 1,2,7
        logic [11:0] waveformGenChannelOutput; // gen1 A..D, gen2, gen3
        logic [3:0]  logicCellOutput;
    } periph_out_s;

    typedef struct packed {
        logic [11:0] waveformGenDriveEn;    // 1 = channel wants its pin driven
        logic        serialClockDriveEn;
    } periph_dir_s;

endpackage

// [design/peripheral_pin_select.sv]
// peripheral pin select: routes peripheral outputs to port pins and pins to inputs
// assumes pin levels arrive asynchronously and peripherals share core_clk
//
// Summary of operation
// RULE_01: code zero drives pin from its output latch
// RULE_02: codes 1-4 route logic cells one to four
// RULE_03: codes 5-16 route generator channels A-D, gens 1-3
// RULE_04: codes 21,22,23 route capture units 1,2,7
// RULE_05: codes 25-27,29-31 route pulse units 3,4,9,5,6,11
// RULE_06: codes 33-37 route serial and uart outputs
// RULE_07: codes 38-43 route synced comparators one to six
// RULE_08: codes 46-48 route modulators one to three
// RULE_09: sources reach only their allowed ports
// RULE_10: generator and serial clock override pin direction
// RULE_11: unsupported selection drives constant low
// RULE_12: input selectors hold 6 bits, upper read zero
// RULE_13: lock bit zero, bits above read zero
// RULE_14: lock set blocks all selection writes
// RULE_15: each pin has its own 6-bit source selector
// RULE_16: input selector feeds peripheral from chosen pin
// RULE_17: unlisted output codes behave as unsupported, low
`timescale 1ns/100ps

module peripheral_pin_select
(
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    // apb register port
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // peripheral side
    input  wire pin_select_pkg::periph_out_s   periphOut,
    input  wire pin_select_pkg::periph_dir_s   periphDir,
    output logic      [42:0]                   periphIn,
    // port pin side
    input  wire logic [23:0]                   pinOutputLatch,
    input  wire logic [23:0]                   pinDirectionControl,
    input  wire logic [23:0]                   pinInput,
    output logic      [23:0]                   pinOutput,
    output logic      [23:0]                   pinOutputEn,
    // status
    output logic                               selectionLocked
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // true when a source code may leave on the given pin
    function automatic logic srcAllowed(input logic [5:0] code, input logic [4:0] pinIdx);
        logic [1:0] port;
        port = pinIdx[4:3];
        if (code == pin_select_pkg::CODE_LATCH)
            srcAllowed = 1'b1;
        else if (port == pin_select_pkg::PORT_FIRST)
            srcAllowed = pin_select_pkg::SRC_ON_FIRST[code];
        else if (port == pin_select_pkg::PORT_SECOND)
            srcAllowed = pin_select_pkg::SRC_ON_SECOND[code];
        else if (port == pin_select_pkg::PORT_THIRD)
            srcAllowed = pin_select_pkg::SRC_ON_FIRST[code]
                       | pin_select_pkg::SRC_ON_SECOND[code];
        else
            srcAllowed = 1'b0;
    endfunction

    function automatic logic isCogCode(input logic [5:0] code);
        isCogCode = (code >= pin_select_pkg::CODE_COG_FIRST)
                 && (code <= pin_select_pkg::CODE_COG_LAST);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0]  outSel_ff [0:23];
    logic [5:0]  inSel_ff  [0:42];
    logic        lock_ff;
    logic [23:0] pinSync1_ff;
    logic [23:0] pinSync2_ff;
    logic [42:0] periphIn_ff;
    logic [23:0] pinOut_ff;
    logic [23:0] pinOe_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    logic [63:0] srcVec;
    logic [23:0] nxt_pinOut;
    logic [23:0] nxt_pinOe;
    logic [42:0] nxt_periphIn;
    logic [31:0] nxt_prdata;
    logic        hitLock;
    logic        hitIn;
    logic        hitOut;
    logic [11:0] inOffset;
    logic [11:0] outOffset;
    logic [5:0]  inIdx;
    logic [4:0]  outIdx;
    logic        accessPend;
    logic        wrCommit;

    // ------------------------------------------------------------
    // source vector, indexed by output code
    // ------------------------------------------------------------
    always_comb
    begin
        srcVec = '0;
        srcVec[4:1]   = periphOut.logicCellOutput;                    // see RULE_02
        srcVec[16:5]  = periphOut.waveformGenChannelOutput;           // see RULE_03
        srcVec[pin_select_pkg::CODE_CCP1]  = periphOut.captureCompareOutput[0]; // see RULE_04
        srcVec[pin_select_pkg::CODE_CCP2]  = periphOut.captureCompareOutput[1]; // see RULE_04
        srcVec[pin_select_pkg::CODE_CCP7]  = periphOut.captureCompareOutput[2]; // see RULE_04
        srcVec[pin_select_pkg::CODE_PWM3]  = periphOut.pulseWidthOutput[0];     // see RULE_05
        srcVec[pin_select_pkg::CODE_PWM4]  = periphOut.pulseWidthOutput[1];     // see RULE_05
        srcVec[pin_select_pkg::CODE_PWM9]  = periphOut.pulseWidthOutput[2];     // see RULE_05
        srcVec[pin_select_pkg::CODE_PWM5]  = periphOut.pulseWidthOutput[3];     // see RULE_05
        srcVec[pin_select_pkg::CODE_PWM6]  = periphOut.pulseWidthOutput[4];     // see RULE_05
        srcVec[pin_select_pkg::CODE_PWM11] = periphOut.pulseWidthOutput[5];     // see RULE_05
        srcVec[37:33] = {periphOut.syncUartDataOut, periphOut.uartTransmitOrClock,
                         periphOut.spiDataOut, periphOut.serialData,
                         periphOut.serialClock};                      // see RULE_06
        srcVec[43:38] = periphOut.syncedComparatorOutput;             // see RULE_07
        srcVec[48:46] = periphOut.modulatorOutput;                    // see RULE_08
        // every other code stays zero, so gaps in the table read low
    end

    // ------------------------------------------------------------
    // output routing per pin
    // ------------------------------------------------------------
    always_comb
    begin
        for (int k = 0; k < 24; k++)
        begin
            logic [5:0] sel;
            logic       ok;
            sel = outSel_ff[k];                                       // see RULE_15
            ok  = srcAllowed(sel, 5'(k));                             // see RULE_09
            if (sel == pin_select_pkg::CODE_LATCH)
                nxt_pinOut[k] = pinOutputLatch[k];                    // see RULE_01
            else if (ok)
                nxt_pinOut[k] = srcVec[sel];
            else
                nxt_pinOut[k] = 1'b0;                                 // see RULE_11 RULE_17
            // peripheral takes over direction only when it is really on the pin
            if (ok && isCogCode(sel))
                nxt_pinOe[k] = periphDir.waveformGenDriveEn[
                    4'(sel - pin_select_pkg::CODE_COG_FIRST)];        // see RULE_10
            else if (ok && sel == pin_select_pkg::CODE_SER_FIRST)
                nxt_pinOe[k] = periphDir.serialClockDriveEn;          // see RULE_10
            else
                nxt_pinOe[k] = ~pinDirectionControl[k];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pinOut_ff <= '0;
            pinOe_ff  <= '0;
        end
        else
        begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff  <= nxt_pinOe;
        end
    end

    // ------------------------------------------------------------
    // input routing
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pinSync1_ff <= '0;
            pinSync2_ff <= '0;
        end
        else
        begin
            pinSync1_ff <= pinInput;
            pinSync2_ff <= pinSync1_ff;
        end
    end

    // codes beyond the last pin feed a low level
    always_comb
    begin
        for (int i = 0; i < 43; i++)
        begin
            if (inSel_ff[i] < 6'(pin_select_pkg::NUM_PINS))
                nxt_periphIn[i] = pinSync2_ff[5'(inSel_ff[i])];       // see RULE_16
            else
                nxt_periphIn[i] = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            periphIn_ff <= '0;
        else
            periphIn_ff <= nxt_periphIn;
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign inOffset  = paddr - pin_select_pkg::ADDR_IN_BASE;
    assign outOffset = paddr - pin_select_pkg::ADDR_OUT_BASE;
    assign inIdx     = inOffset[7:2];
    assign outIdx    = outOffset[6:2];

    always_comb
    begin
        hitLock = 1'b0;
        hitIn   = 1'b0;
        hitOut  = 1'b0;
        if (paddr[1:0] != 2'h0)
            hitLock = 1'b0;
        else if (paddr == pin_select_pkg::ADDR_LOCK)
            hitLock = 1'b1;
        else if (paddr >= pin_select_pkg::ADDR_IN_BASE
                 && inOffset < 12'(4 * pin_select_pkg::NUM_INSEL))
            hitIn = 1'b1;
        else if (paddr >= pin_select_pkg::ADDR_OUT_BASE
                 && outOffset < 12'(4 * pin_select_pkg::NUM_PINS))
            hitOut = 1'b1;
    end

    always_comb
    begin
        nxt_prdata = '0;
        if (hitLock)
            nxt_prdata[pin_select_pkg::LOCK_BIT] = lock_ff;          // see RULE_13
        else if (hitIn)
            nxt_prdata[5:0] = inSel_ff[inIdx];                        // see RULE_12
        else if (hitOut)
            nxt_prdata[5:0] = outSel_ff[outIdx];                      // see RULE_15
    end

    // one wait state: pready rises in the second access cycle
    assign accessPend = psel & penable & ~pready_ff;
    assign wrCommit   = psel & penable & pready_ff & pwrite;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else
        begin
            pready_ff  <= accessPend;
            pslverr_ff <= accessPend & ~(hitLock | hitIn | hitOut);
            prdata_ff  <= (accessPend & ~pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // selection registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            lock_ff <= pin_select_pkg::LOCK_RESET;
        else if (wrCommit && hitLock)
            lock_ff <= pwdata[pin_select_pkg::LOCK_BIT];              // see RULE_13
    end

    // lock freezes both tables; a locked write still completes without error
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 43; i++)
                inSel_ff[i] <= pin_select_pkg::IN_SEL_RESET[i];
            for (int k = 0; k < 24; k++)
                outSel_ff[k] <= pin_select_pkg::OUT_SEL_RESET;
        end
        else if (wrCommit && !lock_ff)                                // see RULE_14
        begin
            if (hitIn)
                inSel_ff[inIdx] <= pwdata[5:0];                       // see RULE_12
            else if (hitOut)
                outSel_ff[outIdx] <= pwdata[5:0];                     // see RULE_15
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign periphIn        = periphIn_ff;
    assign pinOutput       = pinOut_ff;
    assign pinOutputEn     = pinOe_ff;
    assign selectionLocked = lock_ff;

    // ------------------------------------------------------------
    // checks (watched on pin 16, the third port, and pin 0)
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence apbWriteDone;
        psel && penable && pwrite && pready_ff;
    endsequence

    sequence apbReadDone;
        psel && penable && !pwrite && pready_ff;
    endsequence

    chk_latch_route: assert property ( // see RULE_01
        outSel_ff[16] == 6'h00
        |=> pinOut_ff[16] == $past(pinOutputLatch[16]))
        else $error("latch code did not drive latch level");
    chk_cell_route: assert property ( // see RULE_02
        outSel_ff[16] == pin_select_pkg::CODE_LC_LAST
        |=> pinOut_ff[16] == $past(periphOut.logicCellOutput[3]))
        else $error("logic cell four not routed");
    chk_wave_route: assert property ( // see RULE_03
        outSel_ff[16] == pin_select_pkg::CODE_COG_LAST
        |=> pinOut_ff[16] == $past(periphOut.waveformGenChannelOutput[11]))
        else $error("generator three channel D not routed");
    chk_capture_route: assert property ( // see RULE_04
        outSel_ff[16] == pin_select_pkg::CODE_CCP7
        |=> pinOut_ff[16] == $past(periphOut.captureCompareOutput[2]))
        else $error("capture unit 7 not routed");
    chk_pulse_route: assert property ( // see RULE_05
        outSel_ff[16] == pin_select_pkg::CODE_PWM5
        |=> pinOut_ff[16] == $past(periphOut.pulseWidthOutput[3]))
        else $error("pulse unit 5 not routed");
    chk_serial_route: assert property ( // see RULE_06
        outSel_ff[16] == pin_select_pkg::CODE_SER_LAST
        |=> pinOut_ff[16] == $past(periphOut.syncUartDataOut))
        else $error("sync uart data not routed");
    chk_comp_route: assert property ( // see RULE_07
        outSel_ff[16] == pin_select_pkg::CODE_CMP_FIRST
        |=> pinOut_ff[16] == $past(periphOut.syncedComparatorOutput[0]))
        else $error("comparator one not routed");
    chk_mod_route: assert property ( // see RULE_08
        outSel_ff[16] == pin_select_pkg::CODE_MOD_LAST
        |=> pinOut_ff[16] == $past(periphOut.modulatorOutput[2]))
        else $error("modulator three not routed");
    chk_port_gate: assert property ( // see RULE_09
        outSel_ff[0] == pin_select_pkg::CODE_SER_FIRST
        |=> !pinOut_ff[0] && pinOe_ff[0] == !$past(pinDirectionControl[0]))
        else $error("disallowed source reached first port");
    chk_dir_override: assert property ( // see RULE_10
        outSel_ff[16] == pin_select_pkg::CODE_COG_FIRST
        |=> pinOe_ff[16] == $past(periphDir.waveformGenDriveEn[0]))
        else $error("generator did not own pin direction");
    chk_gap_low: assert property ( // see RULE_11 RULE_17
        outSel_ff[16] == 6'h3F || outSel_ff[16] == 6'h11
        |=> !pinOut_ff[16])
        else $error("unsupported code drove pin high");
    chk_insel_read: assert property ( // see RULE_12
        apbReadDone ##0 (paddr == pin_select_pkg::ADDR_IN_BASE)
        |-> prdata_ff[31:6] == 26'h0 && prdata_ff[5:0] == inSel_ff[0])
        else $error("input selector readback wrong");
    chk_lock_read: assert property ( // see RULE_13
        apbReadDone ##0 (paddr == pin_select_pkg::ADDR_LOCK)
        |-> prdata_ff == {31'h0, lock_ff})
        else $error("lock readback wrong");
    chk_lock_hold: assert property ( // see RULE_14
        lock_ff
        |=> $stable(outSel_ff[16]) && $stable(inSel_ff[0]))
        else $error("selection changed while locked");
    chk_outsel_write: assert property ( // see RULE_15
        apbWriteDone ##0 (!lock_ff && paddr == 12'h240)
        |=> outSel_ff[16] == $past(pwdata[5:0]))
        else $error("output selector write lost");
    chk_input_follow: assert property ( // see RULE_16
        inSel_ff[16] == 6'h10
        |=> periphIn_ff[16] == $past(pinInput[16], 3))
        else $error("peripheral input did not follow pin");

endmodule // peripheral_pin_select

// [sim/periph_pad_model.sv]
// far-side model: peripheral output flops and the port pads
// assumes peripherals share core_clk; released pads show the external level
`timescale 1ns/100ps

module periph_pad_model
(
    // clock
    input  wire logic                        core_clk,
    // levels commanded by the bench
    input  wire logic [38:0]                 srcLevels,
    input  wire logic [12:0]                 dirLevels,
    input  wire logic [23:0]                 extLevel,
    // pin drive from the block
    input  wire logic [23:0]                 pinOutput,
    input  wire logic [23:0]                 pinOutputEn,
    // toward the block
    output pin_select_pkg::periph_out_s      periphOut,
    output pin_select_pkg::periph_dir_s      periphDir,
    output logic      [23:0]                 pinInput
);
    // peripherals launch their outputs from core_clk flops
    always_ff @(posedge core_clk)
    begin
        periphOut <= srcLevels;
        periphDir <= dirLevels;
    end

    // a driven pad follows the block, a released one the outside world
    assign pinInput = (pinOutputEn & pinOutput) | (~pinOutputEn & extLevel);
endmodule // periph_pad_model

// [sim/tb_peripheral_pin_select.sv]
// bench for the pin select block: apb register tasks and routing sweeps
// assumes the far-side model in periph_pad_model and the package constants
`timescale 1ns/100ps

module tb_peripheral_pin_select;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, selectionLocked, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [38:0] srcLevels;
    logic [12:0] dirLevels;
    logic [23:0] extLevel, latch, dirCtl, pinInput, pinOutput, pinOutputEn;
    logic [42:0] periphIn;
    pin_select_pkg::periph_out_s periphOut;
    pin_select_pkg::periph_dir_s periphDir;
    int mismatches, checks, p, c, idx, i, v;
    logic ok;

    peripheral_pin_select DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .periphOut(periphOut),
        .periphDir(periphDir), .periphIn(periphIn), .pinOutputLatch(latch),
        .pinDirectionControl(dirCtl), .pinInput(pinInput), .pinOutput(pinOutput),
        .pinOutputEn(pinOutputEn), .selectionLocked(selectionLocked));
    periph_pad_model farSide (.core_clk(core_clk), .srcLevels(srcLevels),
        .dirLevels(dirLevels), .extLevel(extLevel), .pinOutput(pinOutput),
        .pinOutputEn(pinOutputEn), .periphOut(periphOut), .periphDir(periphDir),
        .pinInput(pinInput));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bit of srcLevels that a code selects; -2 latch, -1 none
    function automatic int srcIdx(input int k);
        if (k == 0) return -2;
        if (k <= 16) return k - 1;
        if (k >= 21 && k <= 23) return k - 5;
        if (k >= 25 && k <= 27) return k - 6;
        if (k >= 29 && k <= 31) return k - 7;
        if (k >= 33 && k <= 43) return k - 8;
        if (k >= 46 && k <= 48) return k - 10;
        return -1;
    endfunction

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        mismatches++;
        close_out();
    end

    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata} = '1;
        {psel, penable, pwrite} = '0;
        {srcLevels, dirLevels, extLevel, latch, dirCtl} = '0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        apb(0, pin_select_pkg::ADDR_LOCK, 0);
        chk(r, 0);
        apb(0, 12'hFFC, 0);
        chk({e, r}, {1'b1, 32'h0000_0000});
        // ---------------------------------------------------------------
        // input selectors: defaults, width, pin routing
        // ---------------------------------------------------------------
        dirCtl <= '1;
        for (i = 0; i < 43; i++)
        begin
            apb(0, pin_select_pkg::ADDR_IN_BASE + 12'(4 * i), 0);
            chk(r, pin_select_pkg::IN_SEL_RESET[i]);
            apb(1, pin_select_pkg::ADDR_IN_BASE + 12'(4 * i), 32'hFFFF_FFC0 | (i % 24));
            apb(0, pin_select_pkg::ADDR_IN_BASE + 12'(4 * i), 0);
            chk(r, i % 24);
            for (v = 0; v < 2; v++)
            begin
                extLevel <= v ? ~(24'h00_0001 << (i % 24)) : 24'h00_0001 << (i % 24);
                repeat (5) @(posedge core_clk);
                chk(periphIn[i], !v);
            end
        end
        // ---------------------------------------------------------------
        // lock blocks selector writes but can be cleared
        // ---------------------------------------------------------------
        apb(1, pin_select_pkg::ADDR_LOCK, 32'hFFFF_FFFF);
        apb(0, pin_select_pkg::ADDR_LOCK, 0);
        chk({selectionLocked, r}, {1'b1, 32'h0000_0001});
        apb(1, pin_select_pkg::ADDR_IN_BASE, 32'h0000_0005);
        chk(e, 0);
        apb(0, pin_select_pkg::ADDR_IN_BASE, 0);
        chk(r, 0);
        apb(1, pin_select_pkg::ADDR_OUT_BASE + 12'h040, 32'h0000_0005);
        apb(0, pin_select_pkg::ADDR_OUT_BASE + 12'h040, 0);
        chk(r, 0);
        apb(1, pin_select_pkg::ADDR_LOCK, 0);
        @(posedge core_clk);
        chk(selectionLocked, 0);
        // ---------------------------------------------------------------
        // every output code on one pin of each port
        // ---------------------------------------------------------------
        dirCtl <= '0;
        for (p = 0; p < 3; p++)
            for (c = 0; c < 64; c++)
            begin
                idx = srcIdx(c);
                if (p == 2 || c == 0)
                    ok = (idx != -1);
                else
                    ok = p ? pin_select_pkg::SRC_ON_SECOND[c] : pin_select_pkg::SRC_ON_FIRST[c];
                apb(1, pin_select_pkg::ADDR_OUT_BASE + 12'(32 * p), c);
                srcLevels <= '1;
                latch <= '1;
                repeat (3) @(posedge core_clk);
                chk(pinOutput[8 * p], ok);
                if (ok)
                begin
                    srcLevels <= (idx < 0) ? '1 : ~(39'h1 << idx);
                    latch <= (idx < 0) ? '0 : '1;
                    repeat (3) @(posedge core_clk);
                    chk(pinOutput[8 * p], 0);
                end
            end
        // generator channel and serial clock take the pin direction
        for (c = 0; c < 2; c++)
        begin
            apb(1, pin_select_pkg::ADDR_OUT_BASE + 12'h040, c ? 33 : 5);
            for (v = 0; v < 2; v++)
            begin
                dirLevels <= v ? (c ? 13'h0001 : 13'h0002) : 13'h0000;
                dirCtl <= v ? '1 : '0;
                repeat (3) @(posedge core_clk);
                chk(pinOutputEn[16], v);
            end
        end
        close_out();
    end
endmodule // tb_peripheral_pin_select
